// ### shared/lpr_consts.svh
`ifndef LPR_CONSTS_SVH
`define LPR_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry and sequence edges
// ----------------------------------------------------------------
`define LPR_PIXELS        64
`define LPR_PIX_W         12
`define LPR_LIGHT_W       4
`define LPR_END_EDGE      65
`define LPR_RESTART_EDGE  66
`define LPR_FIFO_DEPTH    16

// ----------------------------------------------------------------
// Timing: figures as printed, cycle counts derived
// ----------------------------------------------------------------
`define LPR_CLK_PERIOD_NS 10
`define LPR_FCLK_MAX_KHZ  5000
`define LPR_HALF_CYC      ((1000000 / `LPR_FCLK_MAX_KHZ / 2 + `LPR_CLK_PERIOD_NS - 1) / `LPR_CLK_PERIOD_NS)
`define LPR_TINT_MIN_MS   0.017
`define LPR_TINT_MAX_MS   100
`define LPR_TINT_MIN_CYC  (int'(`LPR_TINT_MIN_MS * 1.0e6 / `LPR_CLK_PERIOD_NS + 0.4999))
`define LPR_TINT_MAX_CYC  (int'(`LPR_TINT_MAX_MS * 1.0e6 / `LPR_CLK_PERIOD_NS - 0.4999))

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPR_SCLK_RST      1'b0
`define LPR_START_RST     1'b0

`endif

// ### shared/lpr_pkg.sv
package lpr_pkg;

    // Controller sequence state
    typedef enum logic [0:0] {
        lpr_st_idle = 1'b0,
        lpr_st_run  = 1'b1
    } lpr_ctrl_state_t;

    // Sensor clock edge count within one readout
    typedef logic [6:0] lpr_edge_cnt_t;

endpackage : lpr_pkg

// ### shared/lpr_link_if.sv
`timescale 1ns/100ps
`include "lpr_consts.svh"

interface lpr_link_if #(
    parameter int PIX_W = `LPR_PIX_W
) ();
    logic             sensor_clk;          // Sensor clock from controller
    logic             serial_start;        // Start pulse from controller
    logic [PIX_W-1:0] analog_pixel_output; // Pixel level driven by sensor
    logic             analog_oe;           // High while sensor drives output
    logic [PIX_W-1:0] analog_wire;         // Line level seen by the pins

    // Floating output reads as zero through the external pulldown
    assign analog_wire = analog_oe ? analog_pixel_output : '0;

    modport sensor (
        input  sensor_clk,
        input  serial_start,
        output analog_pixel_output,
        output analog_oe
    );

    modport controller (
        output sensor_clk,
        output serial_start,
        input  analog_wire,
        input  analog_oe
    );
endinterface : lpr_link_if

// ### verilog/lpr_sensor.sv
`timescale 1ns/100ps
`include "lpr_consts.svh"

module lpr_sensor #(
    parameter int PIXELS  = `LPR_PIXELS,
    parameter int PIX_W   = `LPR_PIX_W,
    parameter int LIGHT_W = `LPR_LIGHT_W
) (
    input  wire logic                        ref_clk,     // System clock
    input  wire logic                        rst_b,       // Sync reset, active low
    lpr_link_if.sensor                       link,        // Pins toward controller
    input  wire logic [PIXELS*LIGHT_W-1:0]   light_level, // Light per pixel, pixel 0 low
    output logic                             seq_active   // Readout in progress
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (PIXELS < 2 || PIX_W <= LIGHT_W || LIGHT_W < 1) begin : g_bad_param
        $error("lpr_sensor: unsupported geometry");
    end

    localparam int IDX_W = $clog2(PIXELS);

    // One-hot stage vector to pixel index
    function automatic logic [IDX_W-1:0] lpr_stage_idx(input logic [PIXELS-1:0] sr);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int k = 0; k < PIXELS; k++) begin
            if (sr[k]) begin
                idx = IDX_W'(k);
            end
        end
        return idx;
    endfunction : lpr_stage_idx

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic start_s1_reg, start_s2_reg;
    logic sclk_rise;

    // Two flops before use; s3 only gives the edge history of s2
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sclk_s1_reg  <= 1'b0;
            sclk_s2_reg  <= 1'b0;
            sclk_s3_reg  <= 1'b0;
            start_s1_reg <= 1'b0;
            start_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg  <= link.sensor_clk;
            sclk_s2_reg  <= sclk_s1_reg;
            sclk_s3_reg  <= sclk_s2_reg;
            start_s1_reg <= link.serial_start;
            start_s2_reg <= start_s1_reg;
        end
    end

    // The sensor clock is the only timing source of the sequence
    assign sclk_rise = sclk_s2_reg && !sclk_s3_reg; // RQ10

    // ----------------------------------------------------------------
    // Shift register, integrators, output stage
    // ----------------------------------------------------------------
    logic [PIXELS-1:0] sr_reg, sr_next;
    logic [PIX_W-1:0]  integ_reg [PIXELS];
    logic [PIX_W-1:0]  integ_next [PIXELS];
    logic [PIX_W-1:0]  out_reg, out_next;
    logic              oe_reg, oe_next;

    // Next state of the whole readout path
    always_comb begin
        logic [PIX_W:0] sum;
        sum      = '0;
        sr_next  = sr_reg;
        out_next = out_reg;
        if (sclk_rise) begin
            // Start is taken only on a sensor clock rising edge
            sr_next = {sr_reg[PIXELS-2:0], start_s2_reg}; // RQ1 RQ2
        end
        for (int i = 0; i < PIXELS; i++) begin
            sum = {1'b0, integ_reg[i]} + (PIX_W+1)'(light_level[i*LIGHT_W +: LIGHT_W]);
            if (sr_reg[i] && !sr_next[i]) begin
                integ_next[i] = '0; // RQ3
            end else if (sum[PIX_W]) begin
                integ_next[i] = '1; // Saturate rather than wrap
            end else begin
                integ_next[i] = sum[PIX_W-1:0];
            end
        end
        // Stored charge is latched when a stage becomes active
        if (sclk_rise && (|sr_next)) begin
            out_next = integ_reg[lpr_stage_idx(sr_next)]; // RQ2
        end
        // Empty register after the last shift floats the output
        oe_next = |sr_next; // RQ4 RQ9
    end

    // Registers of the readout path
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sr_reg  <= '0;
            out_reg <= '0;
            oe_reg  <= 1'b0;
            for (int i = 0; i < PIXELS; i++) begin
                integ_reg[i] <= '0;
            end
        end else begin
            sr_reg    <= sr_next;
            out_reg   <= out_next;
            oe_reg    <= oe_next;
            integ_reg <= integ_next;
        end
    end

    assign link.analog_pixel_output = out_reg;
    assign link.analog_oe           = oe_reg;
    assign seq_active               = oe_reg;

endmodule : lpr_sensor

// ### verilog/lpr_ctrl.sv
`timescale 1ns/100ps
`include "lpr_consts.svh"

// Contract
// [RQ1] Start pulse captured at exactly one edge
// [RQ2] Start bit shifts through sixty-four stages
// [RQ3] Pixel integrator reset when its stage falls
// [RQ4] Sixty-fifth edge empties register, output floats
// [RQ5] Controller always supplies the sixty-fifth clock
// [RQ6] Next start no earlier than sixty-sixth edge
// [RQ7] Start returns low before following rising edge
// [RQ8] Start interval kept within integration range; a long buffer stall can exceed the maximum, only flagged on tint_late
// [RQ9] Output floats whenever no readout runs
// [RQ10] Single clock times transfer, output, reset
// [RQ11] Controller samples only edges one to sixty-four

// ----------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------
module lpr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = `LPR_FIFO_DEPTH
) (
    input  wire logic             ref_clk,   // System clock
    input  wire logic             rst_b,     // Sync reset, active low
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Write word
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Reader takes word
    output logic      [WIDTH-1:0] out_data   // Oldest word
);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
        $error("lpr_fifo: depth must be a power of two");
    end

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
    logic             push, pop;

    // Extra pointer bit tells full from empty
    assign in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    assign out_valid = (wr_reg != rd_reg);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_reg[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        if (push) begin
            mem_next[wr_reg[AW-1:0]] = in_data;
            wr_next                  = wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = rd_reg + 1'b1;
        end
    end

    // Storage is not reset; pointers alone define content
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        mem_reg <= mem_next;
    end

endmodule : lpr_fifo

// ----------------------------------------------------------------
// Readout controller
// ----------------------------------------------------------------
module lpr_ctrl #(
    parameter int PIXELS       = `LPR_PIXELS,
    parameter int PIX_W        = `LPR_PIX_W,
    parameter int HALF_CYC     = `LPR_HALF_CYC,
    parameter int TINT_MIN_CYC = `LPR_TINT_MIN_CYC,
    parameter int TINT_MAX_CYC = `LPR_TINT_MAX_CYC,
    parameter int INTEG_CYC    = `LPR_TINT_MIN_CYC,
    parameter int TIMER_W      = 24,
    parameter int FIFO_DEPTH   = `LPR_FIFO_DEPTH
) (
    input  wire logic                      ref_clk,   // System clock
    input  wire logic                      rst_b,     // Sync reset, active low
    lpr_link_if.controller                 link,      // Pins toward sensor
    input  wire logic                      run_en,    // Repeat readouts while high
    output logic                           busy,      // Readout in progress
    output logic                           tint_late, // Interval passed the maximum
    output logic                           pix_valid, // Sample available
    input  wire logic                      pix_ready, // Reader takes sample
    output logic [$clog2(PIXELS)-1:0]      pix_index, // Pixel number, 0 first
    output logic [PIX_W-1:0]               pix_data   // Sampled level
);

    localparam int IDX_W = $clog2(PIXELS);
    localparam int PH_W  = $clog2(2 * HALF_CYC);

    if (HALF_CYC < 1 || PIXELS != `LPR_END_EDGE - 1) begin : g_bad_clk
        $error("lpr_ctrl: unsupported clock or pixel count");
    end
    if (INTEG_CYC < TINT_MIN_CYC || INTEG_CYC > TINT_MAX_CYC
        || INTEG_CYC < `LPR_RESTART_EDGE * 2 * HALF_CYC
        || TINT_MAX_CYC >= (2 ** TIMER_W)) begin : g_bad_tint
        $error("lpr_ctrl: integration interval out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lpr_pkg::lpr_ctrl_state_t state_reg, state_next;
    lpr_pkg::lpr_edge_cnt_t   cnt_reg, cnt_next;
    logic [PH_W-1:0]          phase_reg, phase_next;
    logic [TIMER_W-1:0]       timer_reg, timer_next;
    logic                     sclk_reg, sclk_next;
    logic                     start_reg, start_next;
    logic                     late_reg, late_next;
    logic                     rise, fall, sample, stall;
    logic                     fifo_in_ready;
    logic [IDX_W+PIX_W-1:0]   fifo_in_data, fifo_out_data;

    // Sample point is the last cycle before the next rising edge
    assign sample = (phase_reg == PH_W'(2 * HALF_CYC - 1))
                    && (state_reg == lpr_pkg::lpr_st_run)
                    && (cnt_reg >= 7'd1) && (cnt_reg <= 7'(PIXELS)); // RQ11
    // A full buffer holds the sensor clock low; the sensor simply waits
    assign stall  = sample && !fifo_in_ready;
    assign rise   = !stall && (phase_reg == PH_W'(2 * HALF_CYC - 1));
    assign fall   = (phase_reg == PH_W'(HALF_CYC - 1));
    assign fifo_in_data = {IDX_W'(cnt_reg - 7'd1), link.analog_wire};

    // Divider, sequence counter and start pulse
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        start_next = start_reg;
        phase_next = phase_reg;
        timer_next = timer_reg;
        if (timer_reg < TIMER_W'(TINT_MAX_CYC)) begin
            timer_next = timer_reg + 1'b1;
        end
        late_next = run_en && (timer_reg >= TIMER_W'(TINT_MAX_CYC)); // RQ8
        if (!stall) begin
            phase_next = rise ? '0 : phase_reg + 1'b1;
        end
        // Start changes only at the falling edge of the sensor clock
        if (fall) begin
            if (start_reg) begin
                start_next = 1'b0; // RQ1 RQ7
            end else if (run_en && state_reg == lpr_pkg::lpr_st_idle
                         && timer_reg >= TIMER_W'(INTEG_CYC)) begin
                // Idle means edge 65 is past, so the next rise is 66 or later
                start_next = 1'b1; // RQ6 RQ8
            end
        end
        if (rise) begin
            if (start_reg) begin
                cnt_next   = 7'd1;
                state_next = lpr_pkg::lpr_st_run;
                timer_next = '0; // RQ8
            end else if (state_reg == lpr_pkg::lpr_st_run) begin
                cnt_next = cnt_reg + 7'd1;
                // Clock keeps running through edge 65 before idling
                if (cnt_reg == 7'(`LPR_END_EDGE - 1)) begin
                    state_next = lpr_pkg::lpr_st_idle; // RQ5
                end
            end
        end
        sclk_next = (phase_next < PH_W'(HALF_CYC)); // RQ10
    end

    // Registers of the controller
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= lpr_pkg::lpr_st_idle;
            cnt_reg   <= '0;
            phase_reg <= PH_W'(HALF_CYC);
            timer_reg <= '0;
            sclk_reg  <= `LPR_SCLK_RST;
            start_reg <= `LPR_START_RST;
            late_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
            timer_reg <= timer_next;
            sclk_reg  <= sclk_next;
            start_reg <= start_next;
            late_reg  <= late_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs and sample buffer
    // ----------------------------------------------------------------
    assign link.sensor_clk   = sclk_reg;
    assign link.serial_start = start_reg;
    assign busy              = (state_reg == lpr_pkg::lpr_st_run);
    assign tint_late         = late_reg;
    assign pix_index         = fifo_out_data[IDX_W+PIX_W-1:PIX_W];
    assign pix_data          = fifo_out_data[PIX_W-1:0];

    lpr_fifo #(
        .WIDTH (IDX_W + PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (sample),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (fifo_out_data)
    );

endmodule : lpr_ctrl

// ### testbench/lpr_link_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
module lpr_link_monitor #(
    parameter int HALF_CYC  = 10,
    parameter int INTEG_CYC = 1700
) (
    input wire logic        ref_clk,             // System clock
    input wire logic        rst_b,               // Sync reset, active low
    input wire logic        sensor_clk,          // Sensor clock
    input wire logic        serial_start,        // Start pulse
    input wire logic [11:0] analog_pixel_output, // Pixel level
    input wire logic        analog_oe            // Sensor drives output
);
    logic       clk_q_reg, clk_q_next, start_q_reg, start_q_next, seen_reg, seen_next, clk_rise;
    logic [6:0] edge_cnt_reg, edge_cnt_next;
    logic [1:0] st_rises_reg, st_rises_next;
    logic [7:0] hi_cnt_reg, hi_cnt_next;
    logic [15:0] gap_reg, gap_next;

    assign clk_rise = sensor_clk && !clk_q_reg;

    // Edge count since capture; 65 means the sequence has ended
    always_comb begin
        clk_q_next    = sensor_clk;
        start_q_next  = serial_start;
        seen_next     = seen_reg || clk_rise;
        edge_cnt_next = edge_cnt_reg;
        if (clk_rise && serial_start) begin
            edge_cnt_next = 7'h01;
        end else if (clk_rise && edge_cnt_reg == 7'h41) begin
            edge_cnt_next = 7'h00;
        end else if (clk_rise && edge_cnt_reg != 7'h00) begin
            edge_cnt_next = edge_cnt_reg + 7'h01;
        end
        st_rises_next = !serial_start ? 2'h0 : st_rises_reg + {1'b0, clk_rise && st_rises_reg != 2'h3};
        hi_cnt_next   = !sensor_clk ? 8'h00 : hi_cnt_reg + {7'h00, hi_cnt_reg != 8'hff};
        // Saturating gap so the first start after reset always passes
        gap_next      = (serial_start && !start_q_reg) ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hffff};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            clk_q_reg    <= 1'b1;
            start_q_reg  <= 1'b0;
            seen_reg     <= 1'b0;
            edge_cnt_reg <= 7'h00;
            st_rises_reg <= 2'h0;
            hi_cnt_reg   <= 8'h00;
            gap_reg      <= 16'hffff;
        end else begin
            clk_q_reg    <= clk_q_next;
            start_q_reg  <= start_q_next;
            seen_reg     <= seen_next;
            edge_cnt_reg <= edge_cnt_next;
            st_rises_reg <= st_rises_next;
            hi_cnt_reg   <= hi_cnt_next;
            gap_reg      <= gap_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_start_one;       st_rises_reg <= 2'h1; endproperty
    property p_start_spacing;   clk_rise && serial_start |-> edge_cnt_reg == 7'h00 || edge_cnt_reg == 7'h41; endproperty
    property p_start_at_low;    $changed(serial_start) |-> !sensor_clk; endproperty
    property p_oe_after_start;  clk_rise && serial_start |-> ##[2:4] analog_oe; endproperty
    property p_float_after_end; clk_rise && edge_cnt_reg == 7'h40 |-> ##[2:4] !analog_oe; endproperty
    property p_oe_during;       edge_cnt_reg >= 7'h02 && edge_cnt_reg <= 7'h40 |-> analog_oe; endproperty
    property p_float_idle;      edge_cnt_reg == 7'h00 |-> !analog_oe; endproperty
    property p_clk_high;        $fell(sensor_clk) && seen_reg |-> hi_cnt_reg == HALF_CYC; endproperty
    property p_start_gap;       $rose(serial_start) |-> gap_reg >= INTEG_CYC - 1; endproperty

    a_start_one:       assert property (p_start_one) else $error("start seen at two rises");
    a_start_spacing:   assert property (p_start_spacing) else $error("start before edge 66");
    a_start_at_low:    assert property (p_start_at_low) else $error("start moved while clock high");
    a_oe_after_start:  assert property (p_oe_after_start) else $error("output not driven after capture");
    a_float_after_end: assert property (p_float_after_end) else $error("output not floated at edge 65");
    a_oe_during:       assert property (p_oe_during) else $error("output dropped mid readout");
    a_float_idle:      assert property (p_float_idle) else $error("output driven while idle");
    a_clk_high:        assert property (p_clk_high) else $error("sensor clock high phase wrong");
    a_start_gap:       assert property (p_start_gap) else $error("starts too close");

    c_readout: cover property (clk_rise && edge_cnt_reg == 7'h40);
    c_ended:   cover property (edge_cnt_reg == 7'h41 && !analog_oe);
    c_start:   cover property ($rose(serial_start));
endmodule : lpr_link_monitor

// ### testbench/linear_pixel_readout_sequencer_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin errors++; $display("BAD %0t %s", $time, msg); end end

module linear_pixel_readout_sequencer_tb_top;
    localparam int HALF = 4;
    logic         ref_clk, rst_b, run_en, pix_ready, busy, tint_late, pix_valid, seq_active, seq_active2;
    logic [5:0]   pix_index;
    logic [11:0]  pix_data;
    logic [255:0] light_level;
    logic         rdy;
    int           errors, compares, word_cnt, rmode, w0, i;
    int           exp_q[$];

    lpr_link_if link ();
    lpr_link_if link2 ();
    lpr_sensor lpr_sensor_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link), .light_level(light_level),
        .seq_active(seq_active));
    lpr_sensor lpr_sensor_i2 (.ref_clk(ref_clk), .rst_b(rst_b), .link(link2), .light_level(light_level),
        .seq_active(seq_active2));
    lpr_ctrl #(.HALF_CYC(HALF), .TINT_MIN_CYC(1400), .TINT_MAX_CYC(3000), .INTEG_CYC(1400)) lpr_ctrl_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(link), .run_en(run_en), .busy(busy), .tint_late(tint_late),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_index(pix_index), .pix_data(pix_data));
    lpr_link_monitor #(.HALF_CYC(HALF), .INTEG_CYC(1400)) lpr_link_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .sensor_clk(link.sensor_clk), .serial_start(link.serial_start),
        .analog_pixel_output(link.analog_pixel_output), .analog_oe(link.analog_oe));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Reader and model: random, stalled or always ready
    // Word checked where ready is raised, settled for the edge that takes it
    always @(negedge ref_clk) begin
        rdy = (rmode == 2) || (rmode == 0 && $urandom_range(3) != 0);
        if (rst_b && pix_valid === 1'b1 && rdy) begin
            `CHK(pix_index, 6'(word_cnt % 64), "pixel order")
            `CHK(pix_data, 12'(exp_q[word_cnt % 64]), "pixel level")
            word_cnt++;
        end
        pix_ready <= rdy;
    end

    task conclude;
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Bounded wait on the readout flag
    task automatic wait_busy(input logic val);
        int n;
        for (n = 0; n < 4000 && busy !== val; n++) @(negedge ref_clk);
        if (busy !== val) begin
            errors++;
            $display("BAD %0t busy wait ran out", $time);
            conclude();
        end
    endtask : wait_busy

    // Mode changes at the rising edge so the reader never races them
    task automatic set_mode(input int m);
        @(posedge ref_clk);
        rmode = m;
    endtask : set_mode

    // Start moves only while the clock is low
    task automatic pulse2(input logic st);
        @(negedge ref_clk) link2.serial_start = st;
        repeat (5) @(negedge ref_clk);
        link2.sensor_clk = 1'b1;
        repeat (5) @(negedge ref_clk);
        link2.sensor_clk = 1'b0;
    endtask : pulse2

    initial begin
        void'($urandom(32'h2e0c2b6e));
        {rst_b, run_en, link2.sensor_clk, link2.serial_start} = 4'h0;
        errors   = 0;
        compares = 0;
        word_cnt = 0;
        rmode    = 1;
        // Pixel 0 always lit, so a missing integrator clear shows
        for (i = 0; i < 64; i++) begin
            light_level[4*i+:4] = (i == 0 || $urandom_range(1) != 0) ? 4'hf : 4'h0;
            exp_q.push_back(light_level[4*i+:4] != 4'h0 ? 4095 : 0);
        end
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        set_mode(0);
        repeat (300) @(negedge ref_clk);
        run_en = 1'b1;
        wait_busy(1'b1);
        `CHK(tint_late, 1'b0, "late flag too early")
        wait_busy(1'b0);
        // Output floats three cycles after the controller idles
        repeat (4) @(negedge ref_clk);
        `CHK(seq_active, 1'b0, "output driven after readout")
        // FIFO fills, sensor clock stops low, then exactly its depth drains
        wait_busy(1'b1);
        set_mode(1);
        repeat (400) @(negedge ref_clk);
        `CHK(link.sensor_clk, 1'b0, "clock not held low")
        `CHK(pix_valid, 1'b1, "buffer empty under stall")
        w0 = word_cnt;
        set_mode(2);
        repeat (16) @(posedge ref_clk);
        rmode = 1;
        @(negedge ref_clk);
        `CHK(word_cnt - w0, 16, "buffer depth")
        set_mode(0);
        wait_busy(1'b0);
        // Long stall pushes the interval past its maximum
        wait_busy(1'b1);
        set_mode(1);
        repeat (3200) @(negedge ref_clk);
        `CHK(tint_late, 1'b1, "late flag missing")
        run_en = 1'b0;
        set_mode(2);
        wait_busy(1'b0);
        repeat (100) @(negedge ref_clk);
        `CHK(word_cnt, 192, "word count")
        `CHK(pix_valid, 1'b0, "buffer not drained")
        // Second sensor: a controller that withholds the 65th clock; dark from here on
        light_level = '0;
        pulse2(1'b1);
        for (i = 0; i < 63; i++) pulse2(1'b0);
        repeat (20) @(negedge ref_clk);
        `CHK(link2.analog_oe, 1'b1, "output ended without edge 65")
        `CHK(link2.analog_wire, 12'(exp_q[63]), "last pixel level")
        pulse2(1'b0);
        repeat (6) @(negedge ref_clk);
        `CHK(link2.analog_oe, 1'b0, "output not floated")
        `CHK(seq_active2, 1'b0, "sequence still active")
        // Restart at edge 66; pixel 0 was cleared when its stage fell, no light since
        pulse2(1'b1);
        repeat (6) @(negedge ref_clk);
        `CHK(link2.analog_oe, 1'b1, "restart at edge 66 ignored")
        `CHK(link2.analog_wire, 12'h000, "integrator not cleared")
        conclude();
    end
endmodule : linear_pixel_readout_sequencer_tb_top
